// ==== link_sync_assertions.sv ====
// Concurrent checks on the link sync request input ports
`timescale 1ns/10ps
`default_nettype none
module link_sync_assertions (
	input wire logic clk, rst_n, readActive, readData, sendCodeSync, sendAlign, sendData,
	ncoSyncPulse, sysrefAlignPulse, sdoOut, sdoOe_n,
	input wire link_sync_pkg::encoding_t encoding
);
	import link_sync_pkg::*;
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	AST_OE: assert property (readActive |=> !sdoOe_n) else $error("sdo idle");
	AST_DAT: assert property (readActive |=> sdoOut == $past(readData)) else $error("sdo data");
	AST_HIZ: assert property (!readActive |=> sdoOe_n) else $error("sdo driven");
	AST_ALN: assert property ($rose(sendAlign) |-> sendAlign [*4] ##1 sendData) else $error("align");
	AST_64: assert property ((encoding == ENC_64B66B) [*3] |-> sendData) else $error("64b");
	AST_NCO: assert property (ncoSyncPulse |=> !ncoSyncPulse) else $error("nco");
	AST_SR: assert property (sysrefAlignPulse |=> !sysrefAlignPulse) else $error("sysref");
	AST_ONE: assert property ($onehot0({sendCodeSync, sendAlign, sendData})) else $error("state");
endmodule : link_sync_assertions
bind link_sync_request_input link_sync_assertions chk (.*);
`default_nettype wire

// ==== link_sync_params.svh ====
// Constants for the link sync request input block
`ifndef LINK_SYNC_PARAMS_SVH
`define LINK_SYNC_PARAMS_SVH
`define SYNC_SEL_SINGLE 1'h0
`define SYNC_SEL_DIFF 1'h1
`define SYNC_INACTIVE 1'h1
`define ALIGN_SEQ_CYCLES 8'h04
`endif

// ==== link_sync_pkg.sv ====
// Types for the link sync request input block
package link_sync_pkg;
	typedef enum logic {ENC_8B10B, ENC_64B66B} encoding_t;
	typedef enum logic [1:0] {ST_IDLE, ST_CODE_SYNC, ST_ALIGN, ST_DATA} link_state_t;
endpackage : link_sync_pkg

// ==== link_sync_request_input.sv ====
// Sync request selection, link start-up sequencing and pin control
`timescale 1ns/10ps
`default_nettype none
`include "link_sync_params.svh"
module link_sync_request_input (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic syncSePin_n,
	input wire logic tmstpDiff_n,
	input wire logic sysrefIn,
	input wire logic syncSel,
	input wire logic tmstpRecvEn,
	input wire link_sync_pkg::encoding_t encoding,
	input wire logic codeSyncDone,
	input wire logic readActive,
	input wire logic readData,
	output link_sync_pkg::link_state_t linkState,
	output logic sendCodeSync,
	output logic sendAlign,
	output logic sendData,
	output logic ncoSyncPulse,
	output logic sysrefAlignPulse,
	output logic sdoOut,
	output logic sdoOe_n
);
	import link_sync_pkg::*;

	// ------------------------------
	// Input synchronisers
	// ------------------------------
	logic seLevel;
	logic diffLevel;
	logic srLevel;

	// Sync pins idle high, so their filters start high
	pin_sync #(
		.RESET_VAL(1'h1)
	) uSe (
		.clk(clk),
		.rst_n(rst_n),
		.pinIn(syncSePin_n),
		.level(seLevel)
	);

	pin_sync #(
		.RESET_VAL(1'h1)
	) uDiff (
		.clk(clk),
		.rst_n(rst_n),
		.pinIn(tmstpDiff_n),
		.level(diffLevel)
	);

	// SYSREF idles low, so no false rise after reset
	pin_sync #(
		.RESET_VAL(1'h0)
	) uSr (
		.clk(clk),
		.rst_n(rst_n),
		.pinIn(sysrefIn),
		.level(srLevel)
	);

	// ------------------------------
	// Source selection
	// ------------------------------
	logic reqN;

	always_comb begin
		if (syncSel == `SYNC_SEL_DIFF) begin
			// Disabled receiver reads as an idle request
			reqN = tmstpRecvEn ? diffLevel : `SYNC_INACTIVE;
		end else begin
			reqN = seLevel;
		end
	end

	// ------------------------------
	// Link state machine
	// ------------------------------
	link_state_t state_r;
	link_state_t state_nxt;
	logic [7:0] cnt_r;
	logic [7:0] cnt_nxt;

	always_comb begin
		state_nxt = state_r;
		cnt_nxt = cnt_r;
		if (encoding == ENC_64B66B) begin
			state_nxt = ST_DATA;
		end else begin
			case (state_r)
				ST_IDLE: begin
					if (!reqN) begin
						state_nxt = ST_CODE_SYNC;
					end
				end
				ST_CODE_SYNC: begin
					if (reqN && codeSyncDone) begin
						state_nxt = ST_ALIGN;
						cnt_nxt = `ALIGN_SEQ_CYCLES;
					end
				end
				ST_ALIGN: begin
					if (!reqN) begin
						state_nxt = ST_CODE_SYNC;
					end else if (cnt_r == 8'h01) begin
						state_nxt = ST_DATA;
					end else begin
						cnt_nxt = cnt_r - 8'h01;
					end
				end
				ST_DATA: begin
					if (!reqN) begin
						state_nxt = ST_CODE_SYNC;
					end
				end
				default: begin
					state_nxt = ST_IDLE;
				end
			endcase
		end
	end
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_r <= ST_IDLE;
			cnt_r <= 8'h00;
		end else begin
			state_r <= state_nxt;
			cnt_r <= cnt_nxt;
		end
	end

	// ------------------------------
	// Request falling edge to oscillator sync
	// ------------------------------
	logic reqPrev_r;
	logic reqPrev_nxt;
	logic nco_r;
	logic nco_nxt;

	// Runs in every encoding mode
	always_comb begin
		reqPrev_nxt = reqN;
		nco_nxt = reqPrev_r & ~reqN;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			reqPrev_r <= 1'h1;
			nco_r <= 1'h0;
		end else begin
			reqPrev_r <= reqPrev_nxt;
			nco_r <= nco_nxt;
		end
	end

	// ------------------------------
	// SYSREF rising edge to timing alignment
	// ------------------------------
	logic srPrev_r;
	logic srPrev_nxt;
	logic srp_r;
	logic srp_nxt;

	always_comb begin
		srPrev_nxt = srLevel;
		srp_nxt = ~srPrev_r & srLevel;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			srPrev_r <= 1'h0;
			srp_r <= 1'h0;
		end else begin
			srPrev_r <= srPrev_nxt;
			srp_r <= srp_nxt;
		end
	end

	// ------------------------------
	// Serial data output control
	// ------------------------------
	logic sdo_r;
	logic sdo_nxt;
	logic oe_r;
	logic oe_nxt;

	// Pin released whenever no read is running
	always_comb begin
		sdo_nxt = readActive ? readData : 1'h0;
		oe_nxt = ~readActive;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sdo_r <= 1'h0;
			oe_r <= 1'h1;
		end else begin
			sdo_r <= sdo_nxt;
			oe_r <= oe_nxt;
		end
	end

	// ------------------------------
	// Outputs
	// ------------------------------
	assign linkState = state_r;
	assign sendCodeSync = (state_r == ST_CODE_SYNC);
	assign sendAlign = (state_r == ST_ALIGN);
	assign sendData = (state_r == ST_DATA);
	assign ncoSyncPulse = nco_r;
	assign sysrefAlignPulse = srp_r;
	assign sdoOut = sdo_r;
	assign sdoOe_n = oe_r;
endmodule : link_sync_request_input
`default_nettype wire

// ==== link_sync_request_input_tb.sv ====
// Testbench for the link sync request input block
`timescale 1ns/10ps
`default_nettype none
module link_sync_request_input_tb;
	import link_sync_pkg::*;
	logic clk = 0, rst_n = 0, want = 0, pin_n, ts_n = 1, sref = 0, sel = 0, en = 0, ok, rd = 0, rdD = 0;
	logic cs, al, dat, oe_n, serial_port_data_out, nco, srp;
	link_state_t ls;
	int ncoCnt = 0, srCnt = 0;
	encoding_t enc = ENC_8B10B;
	int err_total = 0, n_compared = 0, cyc = 0;
	always #10 clk = ~clk;
	sync_rx_model rx (.clk(clk), .want(want), .sendCodeSync(cs), .reqOut_n(pin_n), .lanesOk(ok));
	link_sync_request_input uut (.clk(clk), .rst_n(rst_n), .syncSePin_n(pin_n), .tmstpDiff_n(ts_n),
		.sysrefIn(sref), .syncSel(sel), .tmstpRecvEn(en), .encoding(enc), .codeSyncDone(ok),
		.readActive(rd), .readData(rdD), .linkState(ls), .sendCodeSync(cs), .sendAlign(al), .sendData(dat),
		.ncoSyncPulse(nco), .sysrefAlignPulse(srp), .sdoOut(serial_port_data_out), .sdoOe_n(oe_n));
	task chk(string nm, logic e, logic g);
		n_compared++;
		if (g !== e) begin
			err_total++;
			$display("CHECK FAILED %s exp %b got %b", nm, e, g);
		end
	endtask : chk
	task end_of_test;
		$display("compared %0d errors %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : end_of_test
	task t_link;
		want = 1;
		repeat (6) @(negedge clk);
		chk("codeSync", 1'h1, cs);
		repeat (20) @(negedge clk);
		chk("data", 1'h1, dat);
		chk("ncoPulse", 1'h1, ncoCnt == 1);
		want = 0;
	endtask : t_link
	task t_diff;
		sel = 1;
		ts_n = 0;
		repeat (10) @(negedge clk);
		chk("ignored", 1'h1, dat);
		en = 1;
		repeat (10) @(negedge clk);
		chk("diffSync", 1'h1, cs);
		chk("ncoDiff", 1'h1, ncoCnt == 2);
		ts_n = 1;
		sel = 0;
	endtask : t_diff
	task t_64;
		enc = ENC_64B66B;
		sref = 1;
		repeat (8) @(negedge clk);
		chk("data64", 1'h1, dat);
		chk("state64", 1'h1, ls == ST_DATA);
		chk("sysref", 1'h1, srCnt == 1);
		sref = 0;
	endtask : t_64
	task t_sdo;
		rd = 1;
		rdD = 1;
		repeat (2) @(negedge clk);
		chk("oe", 1'h0, oe_n);
		chk("sdo", 1'h1, serial_port_data_out);
		rd = 0;
		repeat (2) @(negedge clk);
		chk("hiz", 1'h1, oe_n);
		chk("sdoIdle", 1'h0, serial_port_data_out);
	endtask : t_sdo
	always @(posedge clk) begin
		cyc++;
		if (nco === 1'h1) ncoCnt++;
		if (srp === 1'h1) srCnt++;
		if (cyc == 2000) begin
			err_total++;
			end_of_test;
		end
	end
	initial begin
		repeat (8) @(negedge clk);
		rst_n = 1;
		repeat (2) @(negedge clk);
		t_link;
		t_diff;
		t_64;
		t_sdo;
		end_of_test;
	end
endmodule : link_sync_request_input_tb
`default_nettype wire

// ==== pin_sync.sv ====
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/10ps
`default_nettype none
module pin_sync #(
	parameter logic RESET_VAL = 1'h1
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic pinIn,
	output logic level
);
	logic s1_r, s2_r, s3_r, level_r;
	logic s1_nxt, s2_nxt, s3_nxt, level_nxt;
	always_comb begin
		s1_nxt = pinIn;
		s2_nxt = s1_r;
		s3_nxt = s2_r;
		level_nxt = (s2_r == s3_r) ? s3_r : level_r;
	end
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s1_r <= RESET_VAL;
			s2_r <= RESET_VAL;
			s3_r <= RESET_VAL;
			level_r <= RESET_VAL;
		end else begin
			s1_r <= s1_nxt;
			s2_r <= s2_nxt;
			s3_r <= s3_nxt;
			level_r <= level_nxt;
		end
	end
	assign level = level_r;
endmodule : pin_sync
`default_nettype wire

// ==== sync_rx_model.sv ====
// Far-side receiver model driving the sync request
`timescale 1ns/10ps
`default_nettype none
module sync_rx_model (
	input wire logic clk,
	input wire logic want,
	input wire logic sendCodeSync,
	output logic reqOut_n = 1'h1,
	output logic lanesOk = 1'h0
);
	always @(posedge clk) begin
		lanesOk <= want & (lanesOk | sendCodeSync);
		reqOut_n <= !want | lanesOk;
	end
endmodule : sync_rx_model
`default_nettype wire
